// >>> include/eer_pkg.sv
// Constants and types shared by the emergency error reporting block
package eer_pkg;
    localparam int ADDR_W = 8;
    localparam int HIST_DEPTH = 15;
    localparam int HIST_IDX_W = 4;
    localparam int CODE_W = 16;
    localparam int SUB_W = 40;
    localparam int IRQ_W = 6;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_LAST_CODE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ERR_REG = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_HIST_CNT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_NODE = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_HIST_BASE = 8'h40;
    // Control register fields
    localparam int CTRL_ACK_BIT = 0;
    localparam int CTRL_LED_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    // Interrupt status bits
    localparam int IRQ_FRAME_SENT = 0;
    localparam int IRQ_FAULT_ENTER = 1;
    localparam int IRQ_ACK_FAIL = 2;
    localparam int IRQ_ACK_OK = 3;
    localparam int IRQ_NEW_ERROR = 4;
    localparam int IRQ_FRAME_LOST = 5;
    // Frame layout
    localparam logic [10:0] EMCY_BASE_ID = 11'h080;
    localparam logic [6:0] NODE_RESET = 7'h01;
    localparam logic [CODE_W-1:0] CODE_NO_ERROR = 16'h0000;
    // Error register byte
    localparam logic [7:0] EREG_NONE = 8'h00;
    localparam logic [7:0] EREG_GENERIC = 8'h01;
    localparam logic [7:0] EREG_CURRENT = 8'h02;
    localparam logic [7:0] EREG_VOLTAGE = 8'h04;
    localparam logic [7:0] EREG_TEMP = 8'h08;
    localparam logic [7:0] EREG_COMM = 8'h10;
    localparam logic [7:0] EREG_PROFILE = 8'h20;
    localparam logic [7:0] EREG_RESERVED = 8'h40;
    localparam logic [7:0] EREG_MANUF = 8'h80;
    // Error code classes, upper nibble and next nibble
    localparam logic [3:0] CLS_CURRENT = 4'h2;
    localparam logic [3:0] CLS_VOLTAGE = 4'h3;
    localparam logic [3:0] CLS_TEMP = 4'h4;
    localparam logic [3:0] CLS_SOFTWARE = 4'h6;
    localparam logic [3:0] CLS_MONITOR = 4'h8;
    localparam logic [3:0] CLS_SUB_COMM = 4'h1;
    localparam logic [3:0] CLS_EXTRA = 4'hF;
    // LED blink timing
    localparam int CLK_HZ = 100_000_000;
    localparam int LED_HALF_MS = 250;
    localparam int LED_HALF_CYC = CLK_HZ / 1000 * LED_HALF_MS;
    localparam logic [3:0] LED_GAP_TICKS = 4'h4;
    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_NOERR = 3'b010,
        ST_FAULT = 3'b100
    } eer_state_t;
    typedef enum logic [3:0] {
        LED_IDLE = 4'b0001,
        LED_GREEN = 4'b0010,
        LED_YELLOW = 4'b0100,
        LED_GAP = 4'b1000
    } eer_led_t;
endpackage

// >>> hw/eer_top.sv
// Emergency error reporting: error state machine, history, frame builder, LED codes
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
module eer_top
    import eer_pkg::*;
#(
    parameter int LED_HALF_CYCLES = LED_HALF_CYC
)
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic init_done_in,
    input wire logic err_valid_in,
    input wire logic [CODE_W-1:0] err_code_in,
    input wire logic err_is_fault_in,
    input wire logic [SUB_W-1:0] err_sub_in,
    input wire logic [3:0] err_led_x_in,
    input wire logic [3:0] err_led_y_in,
    input wire logic cause_active_in,
    output logic emcy_valid_out,
    input wire logic emcy_ready_in,
    output logic [10:0] emcy_id_out,
    output logic [63:0] emcy_data_out,
    output logic drive_stop_out,
    output logic led_green_out,
    output logic led_yellow_out,
    output logic irq_out
);
    eer_state_t state;
    eer_state_t next_state;
    eer_led_t led_state;
    eer_led_t next_led_state;
    logic [1:0] ctrl;
    logic [6:0] node_id;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [CODE_W-1:0] last_code;
    logic [7:0] err_reg;
    logic [CODE_W-1:0] hist [HIST_DEPTH];
    logic [HIST_IDX_W-1:0] hist_cnt;
    logic [3:0] led_x;
    logic [3:0] led_y;
    logic [3:0] led_left;
    logic led_lit;
    logic [31:0] led_div;

    // Bus decode
    wire bus_access = psel_in && penable_in;
    wire bus_done = bus_access && pready_out;
    wire wr_done = bus_done && pwrite_in;
    wire [ADDR_W-1:0] hist_off = paddr_in - ADDR_HIST_BASE;
    wire [HIST_IDX_W-1:0] hist_idx = hist_off[HIST_IDX_W+1:2];
    wire hist_hit = (paddr_in >= ADDR_HIST_BASE) && (hist_off[ADDR_W-1:6] == 2'h0)
        && (hist_off[1:0] == 2'h0) && (hist_idx < HIST_IDX_W'(HIST_DEPTH));
    wire reg_hit = (paddr_in == ADDR_CTRL) || (paddr_in == ADDR_STATUS)
        || (paddr_in == ADDR_LAST_CODE) || (paddr_in == ADDR_ERR_REG)
        || (paddr_in == ADDR_HIST_CNT) || (paddr_in == ADDR_IRQ_STAT)
        || (paddr_in == ADDR_IRQ_CLR) || (paddr_in == ADDR_IRQ_EN)
        || (paddr_in == ADDR_NODE) || hist_hit;
    wire ack_req = wr_done && (paddr_in == ADDR_CTRL) && pwdata_in[CTRL_ACK_BIT];

    // State machine decisions
    wire st_init = (state == ST_INIT);
    wire st_noerr = (state == ST_NOERR);
    wire st_fault = (state == ST_FAULT);
    wire init_zero = st_init && init_done_in && !err_valid_in;
    wire fault_new = err_valid_in && err_is_fault_in && !st_fault;
    wire fault_more = err_valid_in && st_fault;
    wire ack_fail = st_fault && ack_req && (cause_active_in || err_valid_in);
    wire ack_ok = st_fault && ack_req && !cause_active_in && !err_valid_in;
    wire send_err = err_valid_in;
    wire send_zero = init_zero || ack_ok;
    wire send_any = send_err || send_zero;

    // Error class to register bits
    function automatic logic [7:0] class_bits(input logic [CODE_W-1:0] c);
        logic [7:0] b;
        b = EREG_NONE;
        unique case (c[15:12])
            CLS_CURRENT: b = EREG_CURRENT;
            CLS_VOLTAGE: b = EREG_VOLTAGE;
            CLS_TEMP: b = EREG_TEMP;
            CLS_SOFTWARE: b = EREG_PROFILE;
            CLS_MONITOR: b = (c[11:8] == CLS_SUB_COMM) ? EREG_COMM : EREG_NONE;
            CLS_EXTRA: b = (c[11:8] == CLS_EXTRA) ? EREG_MANUF : EREG_NONE;
            default: b = EREG_NONE;
        endcase
        return b;
    endfunction

    wire [7:0] err_cls = class_bits(err_code_in);
    wire [7:0] next_err_reg_raw = send_zero ? EREG_NONE
        : (fault_new || fault_more) ? (err_reg | err_cls | EREG_GENERIC)
        : err_reg;
    wire [7:0] next_err_reg = next_err_reg_raw & ~EREG_RESERVED;

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_INIT:
            begin
                if (fault_new)
                    next_state = ST_FAULT;
                else if (init_zero)
                    next_state = ST_NOERR;
            end
            ST_NOERR:
            begin
                if (fault_new)
                    next_state = ST_FAULT;
            end
            ST_FAULT:
            begin
                if (ack_ok)
                    next_state = ST_NOERR;
            end
            default: next_state = ST_INIT;
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state <= ST_INIT;
            drive_stop_out <= 1'b0;
            err_reg <= EREG_NONE;
        end
        else
        begin
            state <= next_state;
            drive_stop_out <= (next_state == ST_FAULT);
            err_reg <= next_err_reg;
        end
    end

    // Last code and history
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            last_code <= CODE_NO_ERROR;
            hist_cnt <= '0;
            for (int i = 0; i < HIST_DEPTH; i++)
                hist[i] <= CODE_NO_ERROR;
        end
        else if (send_err)
        begin
            last_code <= err_code_in;
            hist[0] <= err_code_in;
            for (int i = 1; i < HIST_DEPTH; i++)
                hist[i] <= hist[i-1];
            if (hist_cnt < HIST_IDX_W'(HIST_DEPTH))
                hist_cnt <= hist_cnt + 1'b1;
        end
    end

    // Emergency frame, bytes least significant first on the data bus
    wire [63:0] next_frame = send_err
        ? {err_sub_in, next_err_reg, err_code_in[7:0], err_code_in[15:8]}
        : {{SUB_W{1'b0}}, EREG_NONE, CODE_NO_ERROR};
    wire [63:0] next_frame_le = {next_frame[63:24], next_frame[23:16],
        next_frame[7:0], next_frame[15:8]};
    wire frame_lost = send_any && emcy_valid_out && !emcy_ready_in;

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            emcy_valid_out <= 1'b0;
            emcy_data_out <= '0;
            emcy_id_out <= EMCY_BASE_ID;
        end
        else if (send_any)
        begin
            emcy_valid_out <= 1'b1;
            emcy_data_out <= next_frame_le;
            emcy_id_out <= EMCY_BASE_ID + {4'h0, node_id};
        end
        else if (emcy_ready_in)
            emcy_valid_out <= 1'b0;
    end

    // Interrupt status: set wins over clear
    wire [IRQ_W-1:0] irq_set = {frame_lost, fault_more, ack_ok, ack_fail, fault_new,
        emcy_valid_out && emcy_ready_in};
    wire [IRQ_W-1:0] irq_clr = (wr_done && paddr_in == ADDR_IRQ_CLR)
        ? pwdata_in[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            irq_stat <= '0;
            irq_out <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            irq_out <= |(next_irq_stat & irq_en);
        end
    end

    // Register writes
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ctrl <= CTRL_RESET;
            irq_en <= '0;
            node_id <= NODE_RESET;
        end
        else if (wr_done)
        begin
            if (paddr_in == ADDR_CTRL)
                ctrl <= {pwdata_in[CTRL_LED_EN_BIT], 1'b0};
            if (paddr_in == ADDR_IRQ_EN)
                irq_en <= pwdata_in[IRQ_W-1:0];
            if (paddr_in == ADDR_NODE)
                node_id <= pwdata_in[6:0];
        end
    end

    // Read mux; one wait state per access
    wire [31:0] rd_data =
        (paddr_in == ADDR_CTRL) ? {30'h0, ctrl} :
        (paddr_in == ADDR_STATUS) ? {28'h0, drive_stop_out, state} :
        (paddr_in == ADDR_LAST_CODE) ? {16'h0, last_code} :
        (paddr_in == ADDR_ERR_REG) ? {24'h0, err_reg} :
        (paddr_in == ADDR_HIST_CNT) ? {28'h0, hist_cnt} :
        (paddr_in == ADDR_IRQ_STAT) ? {26'h0, irq_stat} :
        (paddr_in == ADDR_IRQ_EN) ? {26'h0, irq_en} :
        (paddr_in == ADDR_NODE) ? {25'h0, node_id} :
        hist_hit ? {16'h0, hist[hist_idx]} : 32'h0;

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end
        else if (bus_access && !pready_out)
        begin
            pready_out <= 1'b1;
            pslverr_out <= !reg_hit;
            prdata_out <= (!pwrite_in && reg_hit) ? rd_data : 32'h0;
        end
        else
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // LED blink engine: tick every half period
    wire led_tick = (led_div == LED_HALF_CYCLES - 1);
    wire led_run = st_fault && ctrl[CTRL_LED_EN_BIT];
    wire blink_done = led_tick && led_lit && (led_left == 4'h1);

    always_comb
    begin
        next_led_state = led_state;
        unique case (led_state)
            LED_IDLE:
            begin
                if (led_run && led_tick)
                    next_led_state = (led_x != 4'h0) ? LED_GREEN : LED_YELLOW;
            end
            LED_GREEN:
            begin
                if (blink_done)
                    next_led_state = LED_YELLOW;
            end
            LED_YELLOW:
            begin
                if (blink_done || (led_tick && led_left == 4'h0))
                    next_led_state = LED_GAP;
            end
            LED_GAP:
            begin
                if (led_tick && led_left == 4'h1)
                    next_led_state = LED_IDLE;
            end
            default: next_led_state = LED_IDLE;
        endcase
        if (!led_run)
            next_led_state = LED_IDLE;
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            led_div <= '0;
            led_x <= '0;
            led_y <= '0;
        end
        else
        begin
            led_div <= (led_tick || !led_run) ? 32'h0 : led_div + 32'h1;
            if (fault_new || fault_more)
            begin
                led_x <= err_led_x_in;
                led_y <= err_led_y_in;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            led_state <= LED_IDLE;
            led_left <= '0;
            led_lit <= 1'b0;
            led_green_out <= 1'b0;
            led_yellow_out <= 1'b0;
        end
        else
        begin
            led_state <= next_led_state;
            if (next_led_state != led_state)
            begin
                led_lit <= 1'b0;
                led_left <= (next_led_state == LED_GREEN) ? led_x
                    : (next_led_state == LED_YELLOW) ? led_y
                    : (next_led_state == LED_GAP) ? LED_GAP_TICKS : 4'h0;
            end
            else if (led_tick && led_state != LED_IDLE)
            begin
                led_lit <= !led_lit;
                if (led_lit || led_state == LED_GAP)
                    led_left <= led_left - 4'h1;
            end
            led_green_out <= (next_led_state == LED_GREEN) && (next_led_state == led_state)
                && (led_tick ? !led_lit : led_lit);
            led_yellow_out <= (next_led_state == LED_YELLOW) && (next_led_state == led_state)
                && (led_tick ? !led_lit : led_lit);
        end
    end

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    property p_err_frame;
        err_valid_in |=> emcy_valid_out && emcy_data_out[15:0] == $past(err_code_in);
    endproperty
    a_err_frame: assert property (p_err_frame) else $error("error frame missing");
    property p_last_code;
        err_valid_in |=> last_code == $past(err_code_in);
    endproperty
    a_last_code: assert property (p_last_code) else $error("last code wrong");
    property p_hist_shift;
        err_valid_in |=> hist[0] == $past(err_code_in) && hist[1] == $past(hist[0]);
    endproperty
    a_hist_shift: assert property (p_hist_shift) else $error("history shift wrong");
    property p_init_zero;
        st_init && init_done_in && !err_valid_in |=> st_noerr && emcy_valid_out
            && emcy_data_out[23:0] == 24'h0;
    endproperty
    a_init_zero: assert property (p_init_zero) else $error("init frame wrong");
    property p_fault_enter;
        !st_fault && err_valid_in && err_is_fault_in |=> st_fault && drive_stop_out;
    endproperty
    a_fault_enter: assert property (p_fault_enter) else $error("fault not entered");
    property p_ack_fail;
        st_fault && ack_req && cause_active_in |=> st_fault [*2];
    endproperty
    a_ack_fail: assert property (p_ack_fail) else $error("failed ack left fault");
    property p_ack_ok;
        ack_ok |=> st_noerr && !drive_stop_out && err_reg == EREG_NONE
            && emcy_data_out[15:0] == CODE_NO_ERROR;
    endproperty
    a_ack_ok: assert property (p_ack_ok) else $error("ack did not clear");
    property p_frame_id;
        send_any |=> emcy_id_out == EMCY_BASE_ID + {4'h0, $past(node_id)};
    endproperty
    a_frame_id: assert property (p_frame_id) else $error("frame id wrong");
    property p_generic;
        (st_fault |-> err_reg[0]) and (st_noerr |-> err_reg == EREG_NONE);
    endproperty
    a_generic: assert property (p_generic) else $error("generic bit wrong");
    property p_reserved;
        !err_reg[6] && !emcy_data_out[22];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_warn_run;
        st_noerr && err_valid_in && !err_is_fault_in |=> !drive_stop_out && emcy_valid_out;
    endproperty
    a_warn_run: assert property (p_warn_run) else $error("warning stopped drive");
    property p_led_excl;
        !(led_green_out && led_yellow_out) and (!st_fault |=> !led_green_out);
    endproperty
    a_led_excl: assert property (p_led_excl) else $error("led overlap");
endmodule

// >>> dv/eer_net_master.sv
// Network master model that takes emergency frames and keeps the last one
`timescale 1ns/100ps
module eer_net_master
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic stall_in,
    input wire logic emcy_valid_in,
    input wire logic [10:0] emcy_id_in,
    input wire logic [63:0] emcy_data_in,
    output logic emcy_ready_out,
    output logic [7:0] frame_cnt_out,
    output logic [10:0] last_id_out,
    output logic [63:0] last_data_out
);
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            emcy_ready_out <= 1'b0;
            frame_cnt_out <= 8'h00;
            last_id_out <= 11'h000;
            last_data_out <= 64'h0;
        end
        else
        begin
            // Stalling holds frames pending on the device side
            emcy_ready_out <= !stall_in;
            if (emcy_valid_in && emcy_ready_out)
            begin
                frame_cnt_out <= frame_cnt_out + 8'h01;
                last_id_out <= emcy_id_in;
                last_data_out <= emcy_data_in;
            end
        end
    end
endmodule

// >>> dv/eer_top_test.sv
// Self-checking bench for the emergency error reporting block
`timescale 1ns/100ps
module eer_top_test import eer_pkg::*;;
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, e;
    logic [7:0] paddr, nm_cnt, seen;
    logic [31:0] pwdata, prdata, q;
    logic init_done, ev, fault, cause, ev_out, ready, stop, led_g, led_y, irq, stall;
    logic [15:0] code, c;
    logic [39:0] sub;
    logic [3:0] lx, ly;
    logic [10:0] id, nm_id, exp_id;
    logic [63:0] data, nm_data;
    int miscompares, cmp_count, cyc;

    eer_top #(.LED_HALF_CYCLES(4)) u_eer_top (.mclk_in(clk), .arst_n_in(rst_n),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .init_done_in(init_done), .err_valid_in(ev),
        .err_code_in(code), .err_is_fault_in(fault), .err_sub_in(sub),
        .err_led_x_in(lx), .err_led_y_in(ly), .cause_active_in(cause),
        .emcy_valid_out(ev_out), .emcy_ready_in(ready), .emcy_id_out(id),
        .emcy_data_out(data), .drive_stop_out(stop), .led_green_out(led_g),
        .led_yellow_out(led_y), .irq_out(irq));
    eer_net_master u_eer_net_master (.mclk_in(clk), .arst_n_in(rst_n), .stall_in(stall),
        .emcy_valid_in(ev_out), .emcy_id_in(id), .emcy_data_in(data),
        .emcy_ready_out(ready), .frame_cnt_out(nm_cnt), .last_id_out(nm_id),
        .last_data_out(nm_data));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; answer taken at the rising edge where pready is high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, {32'h0, exp}, {32'h0, q});
    endtask

    task automatic raise(input logic [15:0] cd, input logic f, input logic [3:0] x,
        input logic [3:0] y);
        seen = nm_cnt;
        @(posedge clk);
        ev <= 1'b1;
        code <= cd;
        fault <= f;
        lx <= x;
        ly <= y;
        sub <= {cd, cd, cd[7:0]};
        @(posedge clk);
        ev <= 1'b0;
    endtask

    task automatic frame(input logic [15:0] cd, input string name);
        int n;
        n = 0;
        while (nm_cnt === seen && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        seen = nm_cnt;
        chk(name, {37'h0, exp_id, cd}, {37'h0, nm_id, nm_data[15:0]});
    endtask

    task automatic irq_chk(input logic exp_v);
        repeat (2) @(negedge clk);
        chk("irq line", {63'h0, exp_v}, {63'h0, irq});
    endtask

    task automatic led_chk(input int x, input int y);
        int g, k, n;
        logic pg, py;
        g = 0;
        k = 1;
        n = 0;
        pg = 1'b0;
        while (led_y !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            if (led_g === 1'b1 && !pg) g++;
            pg = led_g;
            n++;
        end
        py = 1'b1;
        while (led_g !== 1'b1 && n < 1000)
        begin
            @(negedge clk);
            if (led_y === 1'b1 && !py) k++;
            py = led_y;
            n++;
        end
        chk("green blinks", 64'(x), 64'(g));
        chk("yellow blinks", 64'(y), 64'(k));
    endtask

    initial
    begin
        {rst_n, psel, pen, pwr, init_done, ev, fault, cause, stall} = 9'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        code = 16'h0000;
        sub = 40'h0;
        lx = 4'h0;
        ly = 4'h0;
        exp_id = 11'h081;
        seen = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_STATUS, 32'h1, "status init");
        rd(ADDR_CTRL, 32'h2, "ctrl reset");
        rd(ADDR_NODE, 32'h1, "node reset");
        init_done <= 1'b1;
        frame(16'h0000, "init frame");
        chk("init ereg", 64'h0, {56'h0, nm_data[23:16]});
        rd(ADDR_STATUS, 32'h2, "status noerr");
        $display("test init done");
        stall <= 1'b1;
        cause <= 1'b1;
        raise(16'h2340, 1'b1, 4'h3, 4'h1);
        led_chk(3, 1);
        stall <= 1'b0;
        frame(16'h2340, "fault frame");
        chk("fault ereg", 64'h3, {56'h0, nm_data[23:16]});
        chk("fault sub", 64'h2340234040, {24'h0, nm_data[63:24]});
        rd(ADDR_STATUS, 32'hC, "status fault");
        rd(ADDR_LAST_CODE, 32'h2340, "last code");
        rd(ADDR_ERR_REG, 32'h3, "err reg");
        $display("test fault entry done");
        wr(ADDR_IRQ_EN, 32'h4);
        wr(ADDR_CTRL, 32'h3);
        rd(ADDR_STATUS, 32'hC, "status ack fail");
        irq_chk(1'b1);
        wr(ADDR_IRQ_EN, 32'h0);
        irq_chk(1'b0);
        wr(ADDR_IRQ_EN, 32'h4);
        wr(ADDR_IRQ_CLR, 32'h4);
        irq_chk(1'b0);
        $display("test ack fail done");
        raise(16'h4310, 1'b1, 4'h1, 4'h3);
        frame(16'h4310, "second frame");
        chk("second ereg", 64'hB, {56'h0, nm_data[23:16]});
        rd(ADDR_HIST_BASE, 32'h4310, "hist 0");
        rd(ADDR_HIST_BASE + 8'h04, 32'h2340, "hist 1");
        rd(ADDR_HIST_CNT, 32'h2, "hist count");
        raise(16'h8110, 1'b1, 4'h2, 4'h2);
        frame(16'h8110, "comm frame");
        chk("comm ereg", 64'h1B, {56'h0, nm_data[23:16]});
        $display("test second error done");
        cause <= 1'b0;
        seen = nm_cnt;
        wr(ADDR_CTRL, 32'h3);
        frame(16'h0000, "ack frame");
        chk("ack ereg", 64'h0, {56'h0, nm_data[23:16]});
        rd(ADDR_STATUS, 32'h2, "status ack ok");
        wr(ADDR_NODE, 32'h5);
        exp_id = 11'h085;
        raise(16'h4301, 1'b0, 4'h0, 4'h0);
        frame(16'h4301, "warn frame");
        rd(ADDR_STATUS, 32'h2, "status warn");
        $display("test ack ok done");
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped err", 64'h1, {63'h0, e});
        chk("unmapped data", 64'h0, {32'h0, q});
        wr(ADDR_STATUS, 32'hFF);
        rd(ADDR_STATUS, 32'h2, "status ro");
        $display("test unmapped done");
        for (int i = 0; i < 16; i++)
        begin
            c = 16'hFF00 | i[15:0];
            raise(c, 1'b0, 4'h0, 4'h0);
            frame(c, "class frame");
        end
        rd(ADDR_HIST_CNT, 32'hF, "hist full");
        rd(ADDR_HIST_BASE, 32'hFF0F, "hist newest");
        rd(ADDR_HIST_BASE + 8'h38, 32'hFF01, "hist oldest");
        rd(ADDR_LAST_CODE, 32'hFF0F, "last code");
        $display("test history done");
        final_report();
    end
endmodule
